// [verification/fec_line_model.sv]
// receive line decoder model: one decoded symbol per go pulse.
// assumes go is raised for a single cycle just after a clock edge.
`timescale 1ns/100ps
module fec_line_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [1:0] sym,
  input wire logic sub,
  output logic rx_bit_valid,
  output logic rx_mark_pos,
  output logic rx_mark_neg,
  output logic rx_subst_codeword
);
  // ==========================================================
  // symbol launch; idle lines show the inverse so stale data never
  // looks like a fresh mark to the counters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_bit_valid <= 1'b0;
      rx_mark_pos <= 1'b0;
      rx_mark_neg <= 1'b0;
      rx_subst_codeword <= 1'b0;
    end else begin
      rx_bit_valid <= go;
      rx_mark_pos <= go ? sym[0] : ~rx_mark_pos;
      rx_mark_neg <= go ? sym[1] : ~rx_mark_neg;
      rx_subst_codeword <= go ? sub : ~rx_subst_codeword;
    end
  end
endmodule

// [verification/tb_fec_error_counters.sv]
// self-checking bench for the error counter block.
// assumes short update counts of 100, 42 and 62 hclk cycles.
`timescale 1ns/100ps
module tb_fec_error_counters
  import fec_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, second_tick, timer_event;
  logic [31:0] hrdata, rd;
  logic go = 1'b0;
  logic sub = 1'b0;
  logic [1:0] sym = 2'h0;
  logic rx_bit_valid, rx_mark_pos, rx_mark_neg, rx_subst_codeword;
  logic [7:0] ev = 8'h00;
  logic [3:0] lvl = 4'h0;
  logic [4:0] ebf = 5'h00;
  logic man = 1'b0;
  logic shr = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int tev_n = 0;
  int t0;
  // ==========================================================
  // design, line model, clock
  fec_error_counters #(.SECOND_COUNT(100), .T1_SUB_COUNT(42),
    .E1_SUB_COUNT(62)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .rx_bit_valid(rx_bit_valid), .rx_mark_pos(rx_mark_pos),
    .rx_mark_neg(rx_mark_neg), .rx_subst_codeword(rx_subst_codeword),
    .receive_frame_loss(lvl[0]), .crc6_error(ev[0]),
    .terminal_framing_bit_error(ev[1]),
    .signaling_framing_bit_error(ev[2]), .fps_error(ev[3]),
    .multiframe_strobe(ev[4]), .crc4_error(ev[5]),
    .fas_word_error(ev[6]), .fas_sync_loss(lvl[1]),
    .crc4_sync_loss(lvl[2]), .multiframe_search(lvl[3]),
    .ebit_strobe(ev[7]), .ebit_value(ebf[4]), .frame_number(ebf[3:0]),
    .manual_update_pin(man), .shared_second_pin(shr),
    .second_tick(second_tick), .timer_event(timer_event));
  fec_line_model line_far (.hclk(hclk), .hresetn(hresetn), .go(go),
    .sym(sym), .sub(sub), .rx_bit_valid(rx_bit_valid),
    .rx_mark_pos(rx_mark_pos), .rx_mark_neg(rx_mark_neg),
    .rx_subst_codeword(rx_subst_codeword));
  always #5 hclk = ~hclk;
  // cycle count for the hang guard, timer pulses for the pin tests
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (timer_event === 1'b1) tev_n <= tev_n + 1;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end
  // ==========================================================
  // tasks
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // single ahb-lite word transfer, waits on hready in both phases
  task automatic xfer(logic [7:0] a, logic w, logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic cnt(string nm, logic [7:0] a, logic [15:0] e);
    rchk(nm, a, {24'h0, e[15:8]});
    rchk(nm, a + 8'h04, {24'h0, e[7:0]});
  endtask
  // pin pulse, then settle past the pin synchroniser
  task automatic latch(logic s);
    if (s) shr <= 1'b1;
    else man <= 1'b1;
    repeat (3) @(posedge hclk);
    shr <= 1'b0;
    man <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask
  // p/n mark, upper case marks a substitution codeword, 0 a space
  task automatic lseq(string s);
    foreach (s[i]) begin
      go <= 1'b1;
      sym <= (s[i] inside {"p", "P"}) ? 2'h1 :
        (s[i] inside {"n", "N"}) ? 2'h2 : 2'h0;
      sub <= (s[i] inside {"P", "N"});
      @(posedge hclk);
      go <= 1'b0;
      @(posedge hclk);
    end
  endtask
  // every framer strobe pulsed twice, one at a time
  task automatic pcase(logic [7:0] ctl, logic [2:0] c, logic [3:0] l,
      logic [4:0] f, logic [15:0] ep, logic [15:0] eo, logic [15:0] ef);
    xfer(CONTROL_ADDR, 1'b1, {24'h0, ctl});
    xfer(CONFIG_ADDR, 1'b1, {26'h0, UPD_MANUAL, 1'b0, c});
    latch(1'b0);
    lvl <= l;
    ebf <= f;
    for (int i = 0; i < 16; i++) begin
      ev <= 8'h01 << (i % 8);
      @(posedge hclk);
      ev <= 8'h00;
      @(posedge hclk);
    end
    latch(1'b0);
    lvl <= 4'h0;
    cnt("path", PATH_HIGH_ADDR, ep);
    cnt("oos", OOS_HIGH_ADDR, eo);
    cnt("febe", FEBE_HIGH_ADDR, ef);
  endtask
  // spacing of timer_event, or of second_tick when t is set
  task automatic per(logic [31:0] c, int p, logic t);
    int n;
    xfer(CONFIG_ADDR, 1'b1, c);
    repeat (2) do @(posedge hclk); while ((t ? second_tick
      : timer_event) !== 1'b1);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((t ? second_tick : timer_event) !== 1'b1);
    chk("period", p, n);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a < 12; a++) rchk("reset", 8'(a * 4), 32'h0);
    xfer(LINE_LOW_ADDR, 1'b1, 32'hFF);
    rchk("ro", LINE_LOW_ADDR, 32'h0);
    xfer(CONFIG_ADDR, 1'b1, 32'h20);
    lvl <= 4'h1;
    latch(1'b0);
    lseq("ppnpp");
    latch(1'b0);
    cnt("line", LINE_HIGH_ADDR, 16'h2);
    lvl <= 4'h0;
    xfer(CONFIG_ADDR, 1'b1, 32'h21);
    lseq("n000000000000000p00000000000000000000n");
    latch(1'b0);
    cnt("line", LINE_HIGH_ADDR, 16'h1);
    xfer(CONTROL_ADDR, 1'b1, 32'h4);
    lseq("p0000000nN00000000pp");
    latch(1'b0);
    cnt("line", LINE_HIGH_ADDR, 16'h2);
    xfer(CONTROL_ADDR, 1'b1, 32'h1);
    lseq("nnppp");
    latch(1'b0);
    cnt("line", LINE_HIGH_ADDR, 16'h1);
    xfer(CONFIG_ADDR, 1'b1, 32'h20);
    lseq("nn");
    latch(1'b0);
    cnt("line", LINE_HIGH_ADDR, 16'h1);
    pcase(8'h0, 3'h0, 4'h0, 5'h00, 16'h2, 16'h0, 16'h0);
    pcase(8'h0, 3'h4, 4'h0, 5'h00, 16'h4, 16'h0, 16'h0);
    pcase(8'h0, 3'h2, 4'h0, 5'h00, 16'h2, 16'h2, 16'h0);
    pcase(8'h2, 3'h2, 4'h0, 5'h00, 16'h2, 16'h2, 16'h0);
    pcase(8'h2, 3'h2, 4'h1, 5'h00, 16'h0, 16'h0, 16'h0);
    pcase(8'h2, 3'h0, 4'h1, 5'h00, 16'h0, 16'h2, 16'h0);
    pcase(8'h9, 3'h0, 4'h0, 5'h0D, 16'h2, 16'h2, 16'h2);
    pcase(8'h9, 3'h0, 4'h0, 5'h0F, 16'h2, 16'h2, 16'h2);
    pcase(8'h9, 3'h0, 4'h0, 5'h1D, 16'h2, 16'h2, 16'h0);
    pcase(8'h1, 3'h0, 4'h0, 5'h0D, 16'h2, 16'h2, 16'h0);
    pcase(8'h9, 3'h0, 4'h0, 5'h0E, 16'h2, 16'h2, 16'h0);
    pcase(8'h9, 3'h0, 4'h8, 5'h0D, 16'h2, 16'h0, 16'h2);
    pcase(8'h9, 3'h0, 4'h3, 5'h0D, 16'h0, 16'h0, 16'h0);
    pcase(8'h9, 3'h0, 4'hC, 5'h0D, 16'h0, 16'h0, 16'h0);
    // saturation: strobe held for more than a full 16-bit count
    xfer(CONTROL_ADDR, 1'b1, 32'h2);
    latch(1'b0);
    ev <= 8'h01;
    repeat (65600) @(posedge hclk);
    ev <= 8'h00;
    latch(1'b0);
    cnt("path", PATH_HIGH_ADDR, COUNT_MAX);
    per(32'h00, 100, 1'b0);
    xfer(CONTROL_ADDR, 1'b1, 32'h0);
    per(32'h10, 42, 1'b0);
    xfer(CONTROL_ADDR, 1'b1, 32'h1);
    per(32'h10, 62, 1'b0);
    per(32'h20, 100, 1'b1);
    rchk("status", STATUS_ADDR, 32'h1);
    xfer(STATUS_ADDR, 1'b1, 32'h1);
    lvl <= 4'h1;
    rchk("status", STATUS_ADDR, 32'h2);
    lvl <= 4'h0;
    xfer(CONTROL_ADDR, 1'b1, 32'h2);
    xfer(CONFIG_ADDR, 1'b1, 32'h30);
    t0 = tev_n;
    latch(1'b1);
    pcase_free: for (int i = 0; i < 3; i++) begin
      ev <= 8'h01;
      @(posedge hclk);
      ev <= 8'h00;
      @(posedge hclk);
    end
    latch(1'b1);
    cnt("path", PATH_HIGH_ADDR, 16'h3);
    chk("timer", t0, tev_n);
    test_done();
  end
endmodule

// [verilog/fec_error_counters.sv]
// error counter block of one t1/e1 receive framer, with an ahb-lite
// slave for the host.
// assumes the framer event strobes are synchronous to hclk; the
// manual update and shared second inputs come from pins.
// Operation
// - four counters latch on second, 42ms t1, 62.5ms e1 or manual
// - automatic update raises a timer indication for the host
// - counters saturate at maximum and never wrap
// - port two may update from port one second timer or manual
// - two same-polarity marks in a row are one bipolar violation
// - with substitution decoding, valid codewords are not violations
// - e1 select bit one counts code violations, zero counts bpvs
// - t1 excess zeros add 16-zero runs, or 8 with b8zs
// - line counter counts regardless of sync state
// - t1 path counter counts crc-6 in esf, ft errors in d4
// - d4 with config bit 2 also counts fs errors
// - t1 path counter halts while frame loss is high
// - e1 path counts crc-4 errors, halts on fas or crc-4 loss
// - each 16-bit counter reads as high then low register
// - t1 mos mode counts out-of-sync multiframes during frame loss
// - t1 bit-error mode counts ft or fps errors, halts on loss
// - e1 oos counts fas word errors, halts on loss or search
// - e1 crc-4 counts zero e-bits in frames 13, 15
// - frame loss is a live level while unsynchronised
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module fec_error_counters
  import fec_pkg::*;
#(
  parameter int SECOND_COUNT = SECOND_CYCLES,
  parameter int T1_SUB_COUNT = T1_SUB_CYCLES,
  parameter int E1_SUB_COUNT = E1_SUB_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic rx_bit_valid,
  input wire logic rx_mark_pos,
  input wire logic rx_mark_neg,
  input wire logic rx_subst_codeword,
  input wire logic receive_frame_loss,
  input wire logic crc6_error,
  input wire logic terminal_framing_bit_error,
  input wire logic signaling_framing_bit_error,
  input wire logic fps_error,
  input wire logic multiframe_strobe,
  input wire logic crc4_error,
  input wire logic fas_word_error,
  input wire logic fas_sync_loss,
  input wire logic crc4_sync_loss,
  input wire logic multiframe_search,
  input wire logic ebit_strobe,
  input wire logic ebit_value,
  input wire logic [3:0] frame_number,
  input wire logic manual_update_pin,
  input wire logic shared_second_pin,
  output logic second_tick,
  output logic timer_event
);

  // ==========================================================
  // saturating helper, used by all four counters
  function automatic logic [15:0] sat_add(input logic [15:0] v,
                                          input logic inc);
    sat_add = (inc && v != COUNT_MAX) ? v + 16'h0001 : v;
  endfunction

  // ==========================================================
  // register state
  logic [7:0] cfg;
  logic [7:0] ctl;
  logic fresh;
  logic [15:0] run [4];
  logic [15:0] held [4];
  logic [26:0] sec_cnt;
  logic [26:0] sub_cnt;
  logic [2:0] man_sync;
  logic [2:0] shr_sync;
  logic last_pol;
  logic seen_mark;
  logic last_bpv_pol;
  logic seen_bpv;
  logic [4:0] zero_run;

  // ==========================================================
  // mode decode
  wire e1_mode = ctl[CTL_E1_BIT];
  wire esf_mode = ctl[CTL_ESF_BIT];
  wire subst_on = ctl[CTL_SUBST_BIT];
  wire crc4_on = ctl[CTL_CRC4_BIT];
  wire [1:0] upd_sel = cfg[CFG_UPD_LSB +: 2];

  // ==========================================================
  // update timers and sources
  wire sec_wrap = sec_cnt == 27'(SECOND_COUNT - 1);
  wire [26:0] sub_last = e1_mode ? 27'(E1_SUB_COUNT - 1)
                                 : 27'(T1_SUB_COUNT - 1);
  wire sub_wrap = sub_cnt >= sub_last;
  // only the second and third sync stages are looked at
  wire man_edge = man_sync[1] & ~man_sync[2];
  wire shr_edge = shr_sync[1] & ~shr_sync[2];
  wire auto_update = (upd_sel == UPD_SECOND && sec_wrap) ||
                     (upd_sel == UPD_SUB && sub_wrap);
  wire ext_update = (upd_sel == UPD_MANUAL && man_edge) ||
                    (upd_sel == UPD_SHARED && shr_edge);
  wire update = auto_update | ext_update;

  // free-running dividers; the second also feeds the partner port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_cnt <= 27'h0000000;
      sub_cnt <= 27'h0000000;
      second_tick <= 1'b0;
      timer_event <= 1'b0;
    end else begin
      sec_cnt <= sec_wrap ? 27'h0000000 : sec_cnt + 27'h0000001;
      sub_cnt <= sub_wrap ? 27'h0000000 : sub_cnt + 27'h0000001;
      second_tick <= sec_wrap;
      timer_event <= auto_update;
    end
  end

  // pin synchronisers for the external update sources
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      man_sync <= 3'h0;
      shr_sync <= 3'h0;
    end else begin
      man_sync <= {man_sync[1:0], manual_update_pin};
      shr_sync <= {shr_sync[1:0], shared_second_pin};
    end
  end

  // ==========================================================
  // line code violation detection
  wire is_mark = rx_mark_pos | rx_mark_neg;
  wire mark_ev = rx_bit_valid & is_mark;
  wire bpv = mark_ev & seen_mark & (rx_mark_pos == last_pol);
  wire bpv_counted = bpv & ~(subst_on & rx_subst_codeword);
  wire cv = bpv_counted & seen_bpv & (rx_mark_pos == last_bpv_pol);
  wire [4:0] zero_limit = subst_on ? ZERO_RUN_SUBST : ZERO_RUN_PLAIN;
  // fires once per run, on the zero that reaches the limit
  wire exz = rx_bit_valid & ~is_mark &
             (zero_run == zero_limit - 5'h01);
  wire line_inc = e1_mode ?
                  (cfg[CFG_LINE_SEL_BIT] ? cv : bpv_counted)
                  : (bpv_counted | (cfg[CFG_LINE_SEL_BIT] & exz));

  // polarity history and zero run length; no sync gating at all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_pol <= 1'b0;
      seen_mark <= 1'b0;
      last_bpv_pol <= 1'b0;
      seen_bpv <= 1'b0;
      zero_run <= 5'h00;
    end else if (rx_bit_valid) begin
      if (is_mark) begin
        last_pol <= rx_mark_pos;
        seen_mark <= 1'b1;
        zero_run <= 5'h00;
      end else if (zero_run != zero_limit) begin
        zero_run <= zero_run + 5'h01;
      end
      if (bpv_counted) begin
        last_bpv_pol <= rx_mark_pos;
        seen_bpv <= 1'b1;
      end
    end
  end

  // ==========================================================
  // path, out-of-sync and far-end block error qualification
  wire e1_sync_ok = ~fas_sync_loss & ~crc4_sync_loss;
  wire t1_path = ~receive_frame_loss &
                 (esf_mode ? crc6_error :
                  (terminal_framing_bit_error |
                   (cfg[CFG_FS_BIT] & signaling_framing_bit_error)));
  wire e1_path = e1_sync_ok & crc4_error;
  wire path_inc = e1_mode ? e1_path : t1_path;
  wire t1_oos_bit = ~receive_frame_loss &
                    (esf_mode ? fps_error
                              : terminal_framing_bit_error);
  wire t1_oos_mos = multiframe_strobe & receive_frame_loss;
  wire e1_oos = ~receive_frame_loss & ~fas_sync_loss &
                ~multiframe_search & fas_word_error;
  wire oos_inc = e1_mode ? e1_oos :
                 (cfg[CFG_OOS_SEL_BIT] ? t1_oos_bit : t1_oos_mos);
  wire ebit_frame = frame_number == EBIT_FRAME_A ||
                    frame_number == EBIT_FRAME_B;
  wire febe_inc = e1_mode & crc4_on & e1_sync_ok & ebit_strobe &
                  ~ebit_value & ebit_frame;
  wire [3:0] incs = {febe_inc, oos_inc, path_inc, line_inc};

  // running counts and their latched copies; an event in the update
  // cycle opens the new interval instead of being lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        run[i] <= 16'h0000;
        held[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (update) begin
          held[i] <= run[i];
          run[i] <= {15'h0000, incs[i]};
        end else begin
          run[i] <= sat_add(run[i], incs[i]);
        end
      end
    end
  end

  // ==========================================================
  // ahb-lite slave, zero wait states, always okay
  logic dp_write;
  logic [7:0] dp_addr;
  wire take = hsel & hready & htrans[1];
  wire [7:0] a_addr = haddr[7:0];
  wire wr_cfg = dp_write && dp_addr == CONFIG_ADDR;
  wire wr_ctl = dp_write && dp_addr == CONTROL_ADDR;
  wire wr_sts = dp_write && dp_addr == STATUS_ADDR;
  logic [7:0] rd_val;

  // read mux; high register of a pair holds bits 15:8
  always_comb begin
    rd_val = 8'h00;
    unique case (a_addr)
      LINE_HIGH_ADDR: rd_val = held[0][15:8];
      LINE_LOW_ADDR: rd_val = held[0][7:0];
      PATH_HIGH_ADDR: rd_val = held[1][15:8];
      PATH_LOW_ADDR: rd_val = held[1][7:0];
      OOS_HIGH_ADDR: rd_val = held[2][15:8];
      OOS_LOW_ADDR: rd_val = held[2][7:0];
      FEBE_HIGH_ADDR: rd_val = held[3][15:8];
      FEBE_LOW_ADDR: rd_val = held[3][7:0];
      CONFIG_ADDR: rd_val = cfg;
      CONTROL_ADDR: rd_val = ctl;
      STATUS_ADDR: rd_val = {6'h00, receive_frame_loss, fresh};
      default: rd_val = 8'h00;
    endcase
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture; read data is loaded for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      dp_write <= take & hwrite;
      dp_addr <= a_addr;
      if (take && !hwrite) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  // writable registers; fresh is write-one-to-clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= CONFIG_RESET;
      ctl <= CONTROL_RESET;
      fresh <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg <= hwdata[7:0];
      end
      if (wr_ctl) begin
        ctl <= hwdata[7:0];
      end
      if (auto_update) begin
        fresh <= 1'b1;
      end else if (wr_sts && hwdata[STS_FRESH_BIT]) begin
        fresh <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  // the path count is the one that the long strobe test drives to the top
  property p_saturate;
    @(posedge hclk) disable iff (!hresetn)
    (run[1] == COUNT_MAX && !update) |=> run[1] == COUNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("path count wrapped");

  property p_latch;
    @(posedge hclk) disable iff (!hresetn)
    update |=> held[1] == $past(run[1]) && run[1] <= 16'h0001;
  endproperty
  a_latch: assert property (p_latch)
    else $error("update did not latch and restart");

  property p_timer;
    @(posedge hclk) disable iff (!hresetn)
    auto_update |=> timer_event && fresh;
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer indication missing");

  property p_t1_path_halt;
    @(posedge hclk) disable iff (!hresetn)
    (!e1_mode && receive_frame_loss && !update) |=>
      run[1] == $past(run[1]);
  endproperty
  a_t1_path_halt: assert property (p_t1_path_halt)
    else $error("t1 path count moved during frame loss");

  property p_e1_path_halt;
    @(posedge hclk) disable iff (!hresetn)
    (e1_mode && (fas_sync_loss || crc4_sync_loss) && !update) |=>
      run[1] == $past(run[1]);
  endproperty
  a_e1_path_halt: assert property (p_e1_path_halt)
    else $error("e1 path counted during sync loss");

  property p_bpv;
    @(posedge hclk) disable iff (!hresetn)
    // symbols arrive at most every other cycle, so allow one idle gap
    (rx_bit_valid && rx_mark_pos && !rx_mark_neg) ##1 !rx_bit_valid ##1
    (rx_bit_valid && rx_mark_pos && !rx_mark_neg && !subst_on &&
     !e1_mode) |-> line_inc;
  endproperty
  a_bpv: assert property (p_bpv)
    else $error("repeated positive mark not counted");

  property p_subst;
    @(posedge hclk) disable iff (!hresetn)
    (subst_on && rx_subst_codeword) |-> !bpv_counted;
  endproperty
  a_subst: assert property (p_subst)
    else $error("substitution codeword counted");

  property p_febe;
    @(posedge hclk) disable iff (!hresetn)
    (!update && !(crc4_on && ebit_strobe && !ebit_value && ebit_frame))
      |=> run[3] == $past(run[3]);
  endproperty
  a_febe: assert property (p_febe)
    else $error("e-bit counted outside frames 13 and 15");

  property p_mos;
    @(posedge hclk) disable iff (!hresetn)
    (!e1_mode && !cfg[CFG_OOS_SEL_BIT] && multiframe_strobe &&
     receive_frame_loss) |-> oos_inc;
  endproperty
  a_mos: assert property (p_mos)
    else $error("out-of-sync multiframe missed");

  property p_manual;
    @(posedge hclk) disable iff (!hresetn)
    (upd_sel == UPD_MANUAL) |-> !auto_update;
  endproperty
  a_manual: assert property (p_manual)
    else $error("automatic update in manual mode");

  c_update: cover property (@(posedge hclk) disable iff (!hresetn)
    update && run[0] != 16'h0000);
  c_sat: cover property (@(posedge hclk) disable iff (!hresetn)
    run[1] == COUNT_MAX);
  c_febe: cover property (@(posedge hclk) disable iff (!hresetn)
    febe_inc);

endmodule

// [verilog/fec_pkg.sv]
// package for the framer error counter block: register map, field
// positions, reset values and timing figures.
// assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus.
package fec_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] LINE_HIGH_ADDR = 8'h00;
  localparam logic [7:0] LINE_LOW_ADDR = 8'h04;
  localparam logic [7:0] PATH_HIGH_ADDR = 8'h08;
  localparam logic [7:0] PATH_LOW_ADDR = 8'h0C;
  localparam logic [7:0] OOS_HIGH_ADDR = 8'h10;
  localparam logic [7:0] OOS_LOW_ADDR = 8'h14;
  localparam logic [7:0] FEBE_HIGH_ADDR = 8'h18;
  localparam logic [7:0] FEBE_LOW_ADDR = 8'h1C;
  localparam logic [7:0] CONFIG_ADDR = 8'h20;
  localparam logic [7:0] CONTROL_ADDR = 8'h24;
  localparam logic [7:0] STATUS_ADDR = 8'h28;
  // ==========================================================
  // counter_config_register fields
  localparam int CFG_LINE_SEL_BIT = 0;
  localparam int CFG_OOS_SEL_BIT = 1;
  localparam int CFG_FS_BIT = 2;
  localparam int CFG_UPD_LSB = 4;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // control register fields
  localparam int CTL_E1_BIT = 0;
  localparam int CTL_ESF_BIT = 1;
  localparam int CTL_SUBST_BIT = 2;
  localparam int CTL_CRC4_BIT = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // status register fields
  localparam int STS_FRESH_BIT = 0;
  localparam int STS_FRAME_LOSS_BIT = 1;
  // ==========================================================
  // update source selection
  localparam logic [1:0] UPD_SECOND = 2'h0;
  localparam logic [1:0] UPD_SUB = 2'h1;
  localparam logic [1:0] UPD_MANUAL = 2'h2;
  localparam logic [1:0] UPD_SHARED = 2'h3;
  // ==========================================================
  // timing: figures in their own unit, counts derived from hclk
  localparam int CLK_MHZ = 100;
  localparam int SECOND_US = 1000000;
  localparam int T1_SUB_US = 42000;
  localparam int E1_SUB_US = 62500;
  localparam int SECOND_CYCLES = SECOND_US * CLK_MHZ;
  localparam int T1_SUB_CYCLES = T1_SUB_US * CLK_MHZ;
  localparam int E1_SUB_CYCLES = E1_SUB_US * CLK_MHZ;
  // excessive zero thresholds
  localparam logic [4:0] ZERO_RUN_PLAIN = 5'h10;
  localparam logic [4:0] ZERO_RUN_SUBST = 5'h08;
  // e-bit frames
  localparam logic [3:0] EBIT_FRAME_A = 4'hD;
  localparam logic [3:0] EBIT_FRAME_B = 4'hF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
endpackage
